// File: src/ampsb_pkg.sv
// register map, reset values and carrier types of the amp control block
package ampsb_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;

	localparam logic [3:0] SLEW_SENSE_OFS   = 4'h0;
	localparam logic [3:0] PWR_CTRL_OFS     = 4'h1;
	localparam logic [3:0] SPEAKER_CONTROL_REG_OFS     = 4'h2;
	localparam logic [3:0] BOOST_CURRENT_LIMIT_OFS         = 4'h3;
	localparam logic [3:0] INFLECT_OFS      = 4'h4;
	localparam logic [3:0] SLOPE_OFS        = 4'h5;
	localparam logic [3:0] HYST_OFS         = 4'h6;
	localparam logic [3:0] ATTACK_OFS       = 4'h7;
	localparam logic [3:0] DECAY_OFS        = 4'h8;
	localparam logic [3:0] CEIL_MAX_OFS     = 4'h9;
	localparam logic [3:0] BROWNOUT_OFS     = 4'hA;
	localparam logic [3:0] TEMP_LIM_OFS     = 4'hB;
	localparam logic [3:0] INT_STATUS_OFS   = 4'hC;
	localparam logic [3:0] INT_MASK_OFS     = 4'hD;
	localparam logic [3:0] STATE_OFS        = 4'hE;

	localparam int unsigned SLEW_LSB        = 5;
	localparam int unsigned RANGE_LSB       = 3;
	localparam int unsigned DEVICE_POWER_FIELD_BIT     = 0;
	localparam int unsigned VSNS_OFF_BIT    = 1;
	localparam int unsigned ISNS_OFF_BIT    = 2;
	localparam int unsigned STYLE_BIT       = 4;
	localparam int unsigned TFB_BIT         = 0;
	localparam int unsigned ST_OVRC_BIT     = 0;
	localparam int unsigned ST_BROWN_BIT    = 1;

	localparam logic [2:0]  SLEW_RST        = 3'h4;
	localparam logic [2:0]  SLEW_MIN_CODE   = 3'h2;
	localparam logic [1:0]  RANGE_RST       = 2'h0;
	localparam logic [1:0]  RANGE_RESERVED  = 2'h3;
	localparam logic        STYLE_RST       = 1'b1;
	localparam logic [1:0]  BOOST_CURRENT_LIMIT_RST        = 2'h3;
	localparam logic [15:0] INFLECT_RST     = 16'h0E10;
	localparam logic [7:0]  SLOPE_RST       = 8'h10;
	localparam logic [15:0] HYST_RST        = 16'h0064;
	localparam logic [15:0] ATTACK_RST      = 16'h0032;
	localparam logic [15:0] DECAY_RST       = 16'h01F4;
	localparam logic [15:0] CEIL_MAX_RST    = 16'h2328;
	localparam logic [15:0] BROWNOUT_RST    = 16'h0A8C;
	localparam logic [15:0] TEMP_LIM_RST    = 16'h0069;

	localparam logic [15:0] VBAT_BOOST_MV   = 16'h0B54;
	localparam logic [15:0] BROWNOUT_MIN_MV = 16'h0A8C;
	localparam logic [15:0] HEADROOM_MV     = 16'h00C8;
	localparam logic [15:0] BOOST_MAX_MV    = 16'h2AF8;

	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} ampsb_bus_type;

	typedef struct packed {
		logic [15:0] idata;
		logic [15:0] vdata;
	} ampsb_sense_type;

	typedef struct packed {
		logic        en;
		logic        bypass;
		logic [15:0] level;
		logic [1:0]  boost_current_limit;
	} ampsb_boost_type;
endpackage

// File: src/ampsb_ctrl.sv
// slew, sense, boost, battery guard and fault control of the amplifier
// What this block does
// - slew code 000/001 reserved, reset 100
// - sense range 1.25/1.5/1.75 A, 11 reserved
// - current sense off bit powers channel down
// - voltage sense off bit powers channel down
// - powered-down channel still sends zero samples
// - boost style 0 tracking, 1 on-off, reset 1
// - on-off boost or level just above need
// - look-ahead enables boost, else bypass it
// - guard attacks above ceiling, releases with hysteresis
// - ceiling flat above inflection, sloped below
// - battery below 2.9 V forces boost on while powered
// - brownout powers down, host re-powers
// - four boost current limits, 3 A at reset
// - over-current while powered shuts class-D down
// - over-current flag sticky until read or reset
// - masked-in over-current raises interrupt
// - thermal fold-back lowers gain above limit
module ampsb_ctrl
	import ampsb_pkg::*;
(
	// clock and reset
	input  wire logic            i_core_clk,
	input  wire logic            i_rst,
	// register port
	input  wire ampsb_bus_type   i_bus,
	output logic [15:0]          o_rdata,
	// analog monitors, millivolts and degrees
	input  wire logic [15:0]     i_vbat_mv,
	input  wire logic [15:0]     i_out_mv,
	input  wire logic [15:0]     i_peak_mv,
	input  wire logic [15:0]     i_die_temp,
	input  wire logic            i_overcurrent,
	// sense converter samples
	input  wire logic            i_sample_stb,
	input  wire ampsb_sense_type i_sense,
	output ampsb_sense_type      o_sense,
	output logic                 o_sample_vld,
	output logic                 o_isense_pwr,
	output logic                 o_vsense_pwr,
	output logic [1:0]           o_isense_range,
	// power stage
	output logic [2:0]           o_slew_code,
	output ampsb_boost_type      o_boost,
	output logic                 o_classd_en,
	output logic [7:0]           o_gain_atten,
	// interrupt
	output logic                 o_irq
);

	typedef struct packed {
		logic [2:0]  slew;
		logic [1:0]  range;
		logic        device_power_field;
		logic        isns_off;
		logic        vsns_off;
		logic        style;
		logic        tfb_en;
		logic [1:0]  boost_current_limit;
		logic [15:0] inflect;
		logic [7:0]  slope;
		logic [15:0] hyst;
		logic [15:0] attack_per;
		logic [15:0] decay_per;
		logic [15:0] ceil_max;
		logic [15:0] bo_thr;
		logic [15:0] temp_lim;
		logic [1:0]  status;
		logic [1:0]  mask;
		logic [7:0]  bg_att;
		logic [7:0]  th_att;
		logic [15:0] bg_tmr;
		logic [15:0] th_tmr;
		ampsb_sense_type sense;
		logic        smp_vld;
		logic        boost_on;
		logic [15:0] blevel;
		logic [15:0] rdata;
	} ampsb_state_type;

	ampsb_state_type s_q;
	ampsb_state_type s_d;

	logic [15:0] diff_mv;
	logic [23:0] drop_prod;
	logic [19:0] drop_mv;
	logic [15:0] ceiling_mv;
	logic [15:0] need_base;
	logic [16:0] need_mv;
	logic [15:0] bo_eff;
	logic        force_boost;
	logic        boost_req;
	logic        brownout;
	logic        oc_fault;
	logic        over_ceil;
	logic        below_rel;
	logic        too_hot;
	logic [8:0]  att_sum;
	logic        wr_hit;
	logic [3:0]  a;

	// battery-dependent output ceiling
	always_comb begin
		diff_mv   = (i_vbat_mv < s_q.inflect) ? s_q.inflect - i_vbat_mv
			: 16'h0000;
		drop_prod = diff_mv * s_q.slope;
		drop_mv   = drop_prod[23:4];
		// a steep slope may pull the ceiling all the way to zero
		if (drop_mv >= {4'h0, s_q.ceil_max}) begin
			ceiling_mv = 16'h0000;
		end else begin
			ceiling_mv = s_q.ceil_max - drop_mv[15:0];
		end
	end

	// look-ahead demand and fault detection
	always_comb begin
		need_base   = (i_peak_mv > i_out_mv) ? i_peak_mv : i_out_mv;
		need_mv     = {1'b0, need_base} + {1'b0, HEADROOM_MV};
		force_boost = i_vbat_mv < VBAT_BOOST_MV;
		boost_req   = s_q.device_power_field
			& (force_boost | (need_mv >= {1'b0, i_vbat_mv}));
		// the threshold in use cannot go below the documented floor; the register keeps the written value
		bo_eff      = (s_q.bo_thr < BROWNOUT_MIN_MV) ? BROWNOUT_MIN_MV
			: s_q.bo_thr;
		brownout    = s_q.device_power_field & (i_vbat_mv < bo_eff);
		oc_fault    = s_q.device_power_field & i_overcurrent;
		over_ceil   = i_out_mv > ceiling_mv;
		below_rel   = ({1'b0, i_out_mv} + {1'b0, s_q.hyst})
			< {1'b0, ceiling_mv};
		too_hot     = s_q.tfb_en & (i_die_temp > s_q.temp_lim);
		att_sum     = {1'b0, s_q.bg_att} + {1'b0, s_q.th_att};
		wr_hit      = i_bus.wr;
		a           = i_bus.addr;
	end

	// next state
	always_comb begin
		s_d         = s_q;
		s_d.smp_vld = 1'b0;

		// register writes
		if (wr_hit) begin
			case (a)
				SLEW_SENSE_OFS: begin
					// reserved codes are dropped, old setting stays
					if (i_bus.wdata[SLEW_LSB +: 3] >= SLEW_MIN_CODE) begin
						s_d.slew = i_bus.wdata[SLEW_LSB +: 3];
					end
					if (i_bus.wdata[RANGE_LSB +: 2] != RANGE_RESERVED) begin
						s_d.range = i_bus.wdata[RANGE_LSB +: 2];
					end
				end
				PWR_CTRL_OFS: begin
					s_d.device_power_field  = i_bus.wdata[DEVICE_POWER_FIELD_BIT];
					s_d.isns_off = i_bus.wdata[ISNS_OFF_BIT];
					s_d.vsns_off = i_bus.wdata[VSNS_OFF_BIT];
				end
				SPEAKER_CONTROL_REG_OFS: begin
					s_d.style  = i_bus.wdata[STYLE_BIT];
					s_d.tfb_en = i_bus.wdata[TFB_BIT];
				end
				BOOST_CURRENT_LIMIT_OFS:     s_d.boost_current_limit       = i_bus.wdata[1:0];
				INFLECT_OFS:  s_d.inflect    = i_bus.wdata;
				SLOPE_OFS:    s_d.slope      = i_bus.wdata[7:0];
				HYST_OFS:     s_d.hyst       = i_bus.wdata;
				ATTACK_OFS:   s_d.attack_per = i_bus.wdata;
				DECAY_OFS:    s_d.decay_per  = i_bus.wdata;
				CEIL_MAX_OFS: s_d.ceil_max   = i_bus.wdata;
				BROWNOUT_OFS: s_d.bo_thr     = i_bus.wdata;
				TEMP_LIM_OFS: s_d.temp_lim   = i_bus.wdata;
				INT_MASK_OFS: s_d.mask       = i_bus.wdata[1:0];
				default: begin
				end
			endcase
		end

		// reads answer next cycle; the status read clears its flags
		s_d.rdata = 16'h0000;
		if (i_bus.rd) begin
			case (a)
				SLEW_SENSE_OFS: begin
					s_d.rdata[SLEW_LSB +: 3]  = s_q.slew;
					s_d.rdata[RANGE_LSB +: 2] = s_q.range;
				end
				PWR_CTRL_OFS: begin
					s_d.rdata[DEVICE_POWER_FIELD_BIT]  = s_q.device_power_field;
					s_d.rdata[ISNS_OFF_BIT] = s_q.isns_off;
					s_d.rdata[VSNS_OFF_BIT] = s_q.vsns_off;
				end
				SPEAKER_CONTROL_REG_OFS: begin
					s_d.rdata[STYLE_BIT] = s_q.style;
					s_d.rdata[TFB_BIT]   = s_q.tfb_en;
				end
				BOOST_CURRENT_LIMIT_OFS:     s_d.rdata[1:0] = s_q.boost_current_limit;
				INFLECT_OFS:  s_d.rdata      = s_q.inflect;
				SLOPE_OFS:    s_d.rdata[7:0] = s_q.slope;
				HYST_OFS:     s_d.rdata      = s_q.hyst;
				ATTACK_OFS:   s_d.rdata      = s_q.attack_per;
				DECAY_OFS:    s_d.rdata      = s_q.decay_per;
				CEIL_MAX_OFS: s_d.rdata      = s_q.ceil_max;
				BROWNOUT_OFS: s_d.rdata      = s_q.bo_thr;
				TEMP_LIM_OFS: s_d.rdata      = s_q.temp_lim;
				INT_STATUS_OFS: begin
					s_d.rdata[1:0] = s_q.status;
					s_d.status     = 2'h0;
				end
				INT_MASK_OFS: s_d.rdata[1:0] = s_q.mask;
				STATE_OFS: begin
					s_d.rdata[15:8] = o_gain_atten;
					s_d.rdata[1]    = s_q.boost_on;
					s_d.rdata[0]    = s_q.device_power_field;
				end
				default: begin
				end
			endcase
		end

		// faults: power goes down and stays down until the host
		// writes the power field again; set is applied after clear
		if (oc_fault) begin
			s_d.device_power_field              = 1'b0;
			s_d.status[ST_OVRC_BIT]  = 1'b1;
		end
		if (brownout) begin
			s_d.device_power_field              = 1'b0;
			s_d.status[ST_BROWN_BIT] = 1'b1;
		end

		// boost on/off and target level
		s_d.boost_on = boost_req;
		if (s_q.style) begin
			s_d.blevel = BOOST_MAX_MV;
		end else if (need_mv[16]) begin
			s_d.blevel = 16'hFFFF;
		end else begin
			s_d.blevel = need_mv[15:0];
		end

		// battery guard: one step per attack or decay period
		if (over_ceil) begin
			if (s_q.bg_tmr >= s_q.attack_per) begin
				s_d.bg_tmr = 16'h0000;
				if (s_q.bg_att != 8'hFF) begin
					s_d.bg_att = s_q.bg_att + 8'h01;
				end
			end else begin
				s_d.bg_tmr = s_q.bg_tmr + 16'h0001;
			end
		end else if (below_rel && s_q.bg_att != 8'h00) begin
			if (s_q.bg_tmr >= s_q.decay_per) begin
				s_d.bg_tmr = 16'h0000;
				s_d.bg_att = s_q.bg_att - 8'h01;
			end else begin
				s_d.bg_tmr = s_q.bg_tmr + 16'h0001;
			end
		end else begin
			s_d.bg_tmr = 16'h0000;
		end

		// thermal fold-back shares the attack and decay pacing
		if (too_hot) begin
			if (s_q.th_tmr >= s_q.attack_per) begin
				s_d.th_tmr = 16'h0000;
				if (s_q.th_att != 8'hFF) begin
					s_d.th_att = s_q.th_att + 8'h01;
				end
			end else begin
				s_d.th_tmr = s_q.th_tmr + 16'h0001;
			end
		end else if (s_q.th_att != 8'h00) begin
			if (s_q.th_tmr >= s_q.decay_per) begin
				s_d.th_tmr = 16'h0000;
				s_d.th_att = s_q.th_att - 8'h01;
			end else begin
				s_d.th_tmr = s_q.th_tmr + 16'h0001;
			end
		end else begin
			s_d.th_tmr = 16'h0000;
		end

		// sample slots keep coming; muted channels carry zeros
		if (i_sample_stb) begin
			s_d.smp_vld     = 1'b1;
			s_d.sense.idata = s_q.isns_off ? 16'h0000
				: i_sense.idata;
			s_d.sense.vdata = s_q.vsns_off ? 16'h0000
				: i_sense.vdata;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q            <= '0;
			s_q.slew       <= SLEW_RST;
			s_q.range      <= RANGE_RST;
			s_q.style      <= STYLE_RST;
			s_q.boost_current_limit       <= BOOST_CURRENT_LIMIT_RST;
			s_q.inflect    <= INFLECT_RST;
			s_q.slope      <= SLOPE_RST;
			s_q.hyst       <= HYST_RST;
			s_q.attack_per <= ATTACK_RST;
			s_q.decay_per  <= DECAY_RST;
			s_q.ceil_max   <= CEIL_MAX_RST;
			s_q.bo_thr     <= BROWNOUT_RST;
			s_q.temp_lim   <= TEMP_LIM_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs
	assign o_rdata        = s_q.rdata;
	assign o_sense        = s_q.sense;
	assign o_sample_vld   = s_q.smp_vld;
	assign o_isense_pwr   = ~s_q.isns_off;
	assign o_vsense_pwr   = ~s_q.vsns_off;
	assign o_isense_range = s_q.range;
	assign o_slew_code    = s_q.slew;
	assign o_boost.en     = s_q.boost_on;
	assign o_boost.bypass = ~s_q.boost_on;
	assign o_boost.level  = s_q.blevel;
	assign o_boost.boost_current_limit   = s_q.boost_current_limit;
	assign o_classd_en    = s_q.device_power_field;
	assign o_gain_atten   = att_sum[8] ? 8'hFF : att_sum[7:0];
	assign o_irq          = |(s_q.status & s_q.mask);

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	sequence oc_hit_s;
		s_q.device_power_field && i_overcurrent;
	endsequence
	sequence shut_s;
		!o_classd_en && s_q.status[ST_OVRC_BIT];
	endsequence

	slew_reserved_a: assert property (
		i_bus.wr && i_bus.addr == SLEW_SENSE_OFS
		&& i_bus.wdata[SLEW_LSB +: 3] < SLEW_MIN_CODE
		|=> o_slew_code == $past(o_slew_code))
		else $error("reserved slew code was taken");
	range_reserved_a: assert property (
		i_bus.wr && i_bus.addr == SLEW_SENSE_OFS
		&& i_bus.wdata[RANGE_LSB +: 2] == RANGE_RESERVED
		|=> o_isense_range == $past(o_isense_range))
		else $error("reserved sense range was taken");
	isense_null_a: assert property (
		i_sample_stb && !o_isense_pwr
		|=> o_sample_vld && o_sense.idata == 16'h0000)
		else $error("muted current slot not zero");
	vsense_null_a: assert property (
		i_sample_stb && !o_vsense_pwr
		|=> o_sample_vld && o_sense.vdata == 16'h0000)
		else $error("muted voltage slot not zero");
	low_bat_boost_a: assert property (
		s_q.device_power_field && i_vbat_mv < VBAT_BOOST_MV
		|=> o_boost.en && !o_boost.bypass)
		else $error("boost not forced at low battery");
	onoff_level_a: assert property (
		s_q.style |=> o_boost.level == BOOST_MAX_MV)
		else $error("on-off boost level not at maximum");
	boost_release_a: assert property (
		s_q.device_power_field && !force_boost && need_mv < {1'b0, i_vbat_mv}
		|=> !o_boost.en ##0 o_boost.bypass)
		else $error("boost kept on without demand");
	oc_shutdown_a: assert property (
		oc_hit_s |=> shut_s ##1 !o_classd_en || $past(i_bus.wr))
		else $error("over-current did not shut down");
	oc_irq_a: assert property (
		oc_hit_s and (s_q.mask[ST_OVRC_BIT]
		&& !(i_bus.wr && i_bus.addr == INT_MASK_OFS)) |=> o_irq)
		else $error("unmasked over-current without interrupt");
	set_wins_a: assert property (
		oc_hit_s and (i_bus.rd && i_bus.addr == INT_STATUS_OFS)
		|=> s_q.status[ST_OVRC_BIT])
		else $error("over-current lost to status read");
	brownout_off_a: assert property (
		s_q.device_power_field && i_vbat_mv < BROWNOUT_MIN_MV
		|=> !o_classd_en && s_q.status[ST_BROWN_BIT])
		else $error("brownout did not power down");
	ceiling_flat_a: assert property (
		i_vbat_mv >= s_q.inflect |-> ceiling_mv == s_q.ceil_max)
		else $error("ceiling not flat above inflection");
	guard_quiet_a: assert property (
		!over_ceil |=> s_q.bg_att <= $past(s_q.bg_att))
		else $error("guard attacked below ceiling");
	fold_off_a: assert property (
		!s_q.tfb_en |=> s_q.th_att <= $past(s_q.th_att))
		else $error("fold-back acted while disabled");

endmodule

// File: tb/ampsb_host.sv
// host model that drives the amp register port
module ampsb_host
	import ampsb_pkg::*;
(
	// clock
	input  wire logic        i_core_clk,
	// register port
	output ampsb_bus_type    o_bus,
	input  wire logic [15:0] i_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial o_bus = '0;

	// one-cycle strobe; the device never makes us wait
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_core_clk);
		o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_core_clk);
		o_bus.wr <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge i_core_clk);
		o_bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge i_core_clk);
		o_bus.rd <= 1'b0;
		#1 d = i_rdata;
	endtask

	// the device never resumes by itself after a shutdown
	task automatic repower(input logic [15:0] ctrl);
		wr(PWR_CTRL_OFS, ctrl | 16'h0001);
	endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench of the amp control block
`define CHK(got, exp) begin \
	n_tests++; \
	if ((got) !== (exp)) begin \
		n_errors++; \
		$display("wrong value at %0t: got %h expected %h", \
			$time, got, exp); \
	end \
end

module tb_top
	import ampsb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic            i_core_clk;
	logic            i_rst;
	ampsb_bus_type   bus;
	logic [15:0]     o_rdata;
	logic [15:0]     i_vbat_mv;
	logic [15:0]     i_out_mv;
	logic [15:0]     i_peak_mv;
	logic [15:0]     i_die_temp;
	logic            i_overcurrent;
	logic            i_sample_stb;
	ampsb_sense_type i_sense;
	ampsb_sense_type o_sense;
	logic            o_sample_vld;
	logic            o_isense_pwr;
	logic            o_vsense_pwr;
	logic [1:0]      o_isense_range;
	logic [2:0]      o_slew_code;
	ampsb_boost_type o_boost;
	logic            o_classd_en;
	logic [7:0]      o_gain_atten;
	logic            o_irq;
	int              n_errors;
	int              n_tests;

	ampsb_ctrl u_ampsb_ctrl (
		.i_core_clk(i_core_clk), .i_rst(i_rst), .i_bus(bus),
		.o_rdata(o_rdata), .i_vbat_mv(i_vbat_mv), .i_out_mv(i_out_mv),
		.i_peak_mv(i_peak_mv), .i_die_temp(i_die_temp),
		.i_overcurrent(i_overcurrent), .i_sample_stb(i_sample_stb),
		.i_sense(i_sense), .o_sense(o_sense), .o_sample_vld(o_sample_vld),
		.o_isense_pwr(o_isense_pwr), .o_vsense_pwr(o_vsense_pwr),
		.o_isense_range(o_isense_range), .o_slew_code(o_slew_code),
		.o_boost(o_boost), .o_classd_en(o_classd_en),
		.o_gain_atten(o_gain_atten), .o_irq(o_irq)
	);

	ampsb_host u_ampsb_host (
		.i_core_clk(i_core_clk), .o_bus(bus), .i_rdata(o_rdata)
	);

	always #10 i_core_clk = ~i_core_clk;

	task automatic close_out();
		$display("checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// registered outputs need a couple of edges to follow a change
	task automatic settle();
		repeat (3) @(posedge i_core_clk);
		#1;
	endtask

	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		logic [15:0] d;
		u_ampsb_host.rd(a, d);
		`CHK(d, e)
	endtask

	// bounded wait, a stuck counter shows up as a mismatch
	task automatic wait_atten(input logic zero);
		for (int i = 0; i < 200; i++) begin
			@(posedge i_core_clk);
			#1;
			if ((o_gain_atten === 8'h00) === zero) break;
		end
		`CHK(o_gain_atten === 8'h00, zero)
	endtask

	task automatic pulse_oc();
		@(posedge i_core_clk);
		i_overcurrent <= 1'b1;
		@(posedge i_core_clk);
		i_overcurrent <= 1'b0;
		settle();
	endtask

	task automatic t_reset();
		`CHK(o_slew_code, 3'h4)
		`CHK(o_isense_range, 2'h0)
		`CHK(o_boost.boost_current_limit, 2'h3)
		`CHK({o_isense_pwr, o_vsense_pwr}, 2'h3)
		rchk(SLEW_SENSE_OFS, 16'h0080);
		rchk(SPEAKER_CONTROL_REG_OFS, 16'h0010);
		rchk(BOOST_CURRENT_LIMIT_OFS, 16'h0003);
		rchk(4'hF, 16'h0000);
	endtask

	// reserved codes must leave the field as it was
	task automatic t_cfg();
		logic [2:0] s;
		logic [1:0] r;
		s = 3'h4;
		r = 2'h0;
		for (int c = 0; c < 8; c++) begin
			u_ampsb_host.wr(SLEW_SENSE_OFS,
				(16'(c) << 5) | (16'(c % 4) << 3));
			if (c >= 2) s = 3'(c);
			if (c % 4 != 3) r = 2'(c % 4);
			settle();
			`CHK(o_slew_code, s)
			`CHK(o_isense_range, r)
		end
		for (int c = 0; c < 4; c++) begin
			u_ampsb_host.wr(BOOST_CURRENT_LIMIT_OFS, 16'(c));
			settle();
			`CHK(o_boost.boost_current_limit, 2'(c))
		end
	endtask

	task automatic t_sense(input logic [15:0] ctrl, input logic ioff,
			input logic voff);
		u_ampsb_host.wr(PWR_CTRL_OFS, ctrl);
		settle();
		@(posedge i_core_clk);
		i_sample_stb <= 1'b1;
		@(posedge i_core_clk);
		i_sample_stb <= 1'b0;
		#1;
		`CHK(o_sample_vld, 1'b1)
		`CHK(o_sense.idata, ioff ? 16'h0000 : 16'h1234)
		`CHK(o_sense.vdata, voff ? 16'h0000 : 16'h5678)
		`CHK(o_isense_pwr, !ioff)
		`CHK(o_vsense_pwr, !voff)
	endtask

	task automatic t_boost(input logic [15:0] vb, input logic [15:0] pk,
			input logic en, input logic [15:0] lvl);
		@(posedge i_core_clk);
		i_vbat_mv <= vb;
		i_peak_mv <= pk;
		settle();
		`CHK(o_boost.en, en)
		`CHK(o_boost.bypass, !en)
		if (en) `CHK(o_boost.level, lvl)
	endtask

	task automatic t_guard();
		u_ampsb_host.wr(ATTACK_OFS, 16'h0002);
		u_ampsb_host.wr(DECAY_OFS, 16'h0002);
		@(posedge i_core_clk);
		i_out_mv <= 16'h21FC;
		repeat (20) @(posedge i_core_clk);
		#1;
		`CHK(o_gain_atten, 8'h00)
		@(posedge i_core_clk);
		i_vbat_mv <= 16'h0BB8;
		wait_atten(1'b0);
		@(posedge i_core_clk);
		i_out_mv <= 16'h03E8;
		wait_atten(1'b1);
		u_ampsb_host.wr(SPEAKER_CONTROL_REG_OFS, 16'h0001);
		@(posedge i_core_clk);
		i_die_temp <= 16'h00C8;
		wait_atten(1'b0);
		@(posedge i_core_clk);
		i_die_temp <= 16'h0014;
		wait_atten(1'b1);
	endtask

	task automatic t_fault();
		logic [15:0] d;
		u_ampsb_host.wr(INT_MASK_OFS, 16'h0001);
		pulse_oc();
		`CHK({o_classd_en, o_irq}, 2'b01)
		pulse_oc();
		rchk(INT_STATUS_OFS, 16'h0001);
		`CHK(o_irq, 1'b0)
		rchk(INT_STATUS_OFS, 16'h0000);
		u_ampsb_host.repower(16'h0001);
		settle();
		`CHK(o_classd_en, 1'b1)
		fork
			u_ampsb_host.rd(INT_STATUS_OFS, d);
			pulse_oc();
		join
		`CHK(d, 16'h0000)
		rchk(INT_STATUS_OFS, 16'h0001);
		u_ampsb_host.repower(16'h0001);
		@(posedge i_core_clk);
		i_vbat_mv <= 16'h0A28;
		settle();
		`CHK({o_classd_en, o_irq}, 2'b00)
		@(posedge i_core_clk);
		i_vbat_mv <= 16'h0FA0;
		rchk(INT_STATUS_OFS, 16'h0002);
		u_ampsb_host.repower(16'h0001);
		settle();
		`CHK(o_classd_en, 1'b1)
	endtask

	initial begin
		n_errors = 0;
		n_tests = 0;
		i_core_clk = 1'b0;
		i_rst = 1'b1;
		i_vbat_mv = 16'h0FA0;
		i_out_mv = 16'h03E8;
		i_peak_mv = 16'h0000;
		i_die_temp = 16'h0014;
		i_overcurrent = 1'b0;
		i_sample_stb = 1'b0;
		i_sense = '{idata: 16'h1234, vdata: 16'h5678};
		repeat (2) @(posedge i_core_clk);
		i_rst <= 1'b0;
		#1;
		t_reset();
		t_cfg();
		t_sense(16'h0005, 1'b1, 1'b0);
		t_sense(16'h0003, 1'b0, 1'b1);
		t_sense(16'h0001, 1'b0, 1'b0);
		t_boost(16'h0FA0, 16'h0000, 1'b0, 16'h0000);
		t_boost(16'h0AF0, 16'h0000, 1'b1, 16'h2AF8);
		t_boost(16'h0FA0, 16'h0F3C, 1'b1, 16'h2AF8);
		u_ampsb_host.wr(SPEAKER_CONTROL_REG_OFS, 16'h0000);
		t_boost(16'h0FA0, 16'h0F3C, 1'b1, 16'h1004);
		t_boost(16'h0FA0, 16'h1388, 1'b1, 16'h1450);
		t_boost(16'h0FA0, 16'h0000, 1'b0, 16'h0000);
		t_guard();
		t_fault();
		close_out();
	end
endmodule
